// File: switch_cfg_pkg.sv
// constants, field layout and types of the global configuration register bank
package switch_cfg_pkg;

  // ==========================================================================
  // serial frame layout
  localparam int unsigned FRAME_W = 32;
  localparam int unsigned ADDR_MSB = 31;
  localparam int unsigned ADDR_LSB = 25;
  localparam int unsigned RW_BIT = 24;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned BIT_CNT_W = 5;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h1F;
  localparam logic RW_WRITE = 1'b1;

  // ==========================================================================
  // addresses and fixed answers
  localparam logic [6:0] ADDR_LINK_CHECK = 7'h00;
  localparam logic [6:0] ADDR_GLOBAL_CFG = 7'h01;
  localparam logic [6:0] ADDR_FAULT_STATUS = 7'h21;
  localparam logic [23:0] LINK_CHECK_WORD = 24'h123456;
  localparam logic [7:0] RESP_UPPER = 8'h00;
  localparam logic [3:0] UNUSED_BITS = 4'h0;

  // ==========================================================================
  // configuration field positions
  localparam int unsigned CFG_W = 18;
  localparam int unsigned POLL_LEN_BIT = 17;
  localparam int unsigned OVP_DIS_BIT = 16;
  localparam int unsigned WAKE_QUAL_BIT = 15;
  localparam int unsigned IRQ_STYLE_BIT = 14;
  localparam int unsigned MUX_CFG_MSB = 13;
  localparam int unsigned MUX_CFG_LSB = 12;
  localparam int unsigned POL_MSB = 11;
  localparam int unsigned NUM_PROG = 12;
  localparam logic [17:0] CFG_RESET = 18'h08FFF;
  localparam int unsigned OV_FLAG_BIT = 0;

  // ==========================================================================
  // analog multiplexer selection
  localparam int unsigned MUX_SEL_W = 6;
  localparam int unsigned HW_SEL_W = 3;
  typedef enum logic [1:0] {
    MUX_SERIAL_A = 2'b00,
    MUX_SERIAL_B = 2'b01,
    MUX_HW_TWO = 2'b10,
    MUX_HW_THREE = 2'b11
  } mux_mode_t;

  // ==========================================================================
  // interrupt pin sequencing
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_HELD = 2'b01,
    IRQ_PULSE = 2'b10
  } irq_state_t;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned POLL_LONG_NS = 1_000_000;
  localparam int unsigned POLL_SHORT_NS = 55_000;
  localparam int unsigned IRQ_PULSE_NS = 10_000;
  localparam int unsigned POLL_LONG_CYCLES = (POLL_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POLL_SHORT_CYCLES = (POLL_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IRQ_PULSE_CYCLES = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POLL_CNT_W = 16;
  localparam int unsigned PULSE_CNT_W = 12;

endpackage : switch_cfg_pkg

// File: frame_link_if.sv
// carrier between the link-clock shifter and the system-clock register core
interface frame_link_if;
  logic [31:0] frame_word;
  logic frame_tgl;
  logic [31:0] resp_word;
  logic miso;

  modport shifter (
    output frame_word,
    output frame_tgl,
    output miso,
    input resp_word
  );

  modport core (
    input frame_word,
    input frame_tgl,
    input miso,
    output resp_word
  );
endinterface : frame_link_if

// File: frame_shifter.sv
// serial frame shifter running on the link clock
module frame_shifter
  import switch_cfg_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic mosi,
  frame_link_if.shifter lnk
);

  logic rst_q1_r;
  logic rst_q2_r;
  logic [4:0] bit_cnt_r;
  logic [30:0] rx_r;
  logic [30:0] tx_r;
  logic miso_r;
  logic [31:0] frame_word_r;
  logic frame_tgl_r;

  // ==========================================================================
  // reset carried into the link domain
  always_ff @(posedge link_clk) begin
    rst_q1_r <= rst_n;
    rst_q2_r <= rst_q1_r;
  end

  // ==========================================================================
  // bit counter and receive shift
  always_ff @(posedge link_clk) begin
    if (!rst_q2_r) begin
      bit_cnt_r <= '0;
      rx_r <= '0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
      rx_r <= {rx_r[29:0], mosi};
    end
  end

  // ==========================================================================
  // answer of the previous frame leaves first bit first
  always_ff @(posedge link_clk) begin
    if (!rst_q2_r) begin
      miso_r <= 1'b0;
      tx_r <= '0;
    end else if (bit_cnt_r == '0) begin
      {miso_r, tx_r} <= lnk.resp_word;
    end else begin
      {miso_r, tx_r} <= {tx_r, 1'b0};
    end
  end

  // ==========================================================================
  // completed command handed to the core by toggle
  always_ff @(posedge link_clk) begin
    if (!rst_q2_r) begin
      frame_word_r <= '0;
      frame_tgl_r <= 1'b0;
    end else if (bit_cnt_r == FRAME_LAST_BIT) begin
      frame_word_r <= {rx_r, mosi};
      frame_tgl_r <= ~frame_tgl_r;
    end
  end

  assign lnk.frame_word = frame_word_r;
  assign lnk.frame_tgl = frame_tgl_r;
  assign lnk.miso = miso_r;

endmodule : frame_shifter

// File: switch_cfg_top.sv
// global configuration register bank of the switch detector with its serial port
// Overview of operation
// - bit 17 picks long or short poll
// - overvoltage with protection: 2 mA, no sleep
// - protection disabled: normal currents, sleep allowed
// - overvoltage flag sets regardless of protection
// - qualify off: wake ignored when supply low
// - qualify on: any wake falling edge in low-power state wakes
// - bit 14: latched or pulsed interrupt pin
// - bits 13-12 choose multiplexer select source
// - bits 11-0 set input polarity
// - closed switch always reads as one
// - polarity change raises an interrupt
// - fault flag cleared by fault read, fault gone
// - interrupt flag cleared by any access to the global configuration register, unless an interrupt event sets it in the same cycle
// - frame: address, read/write, 24 data
// - answer comes in the following frame
module switch_cfg_top
  import switch_cfg_pkg::*;
#(
  parameter logic [15:0] POLL_LONG_COUNT = 16'(switch_cfg_pkg::POLL_LONG_CYCLES)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire logic battery_supply_overvoltage,
  input wire logic logic_supply_present,
  input wire logic wake_n,
  input wire logic low_power_state,
  input wire logic fault_event,
  input wire logic fault_present,
  input wire logic switch_change_event,
  input wire logic [switch_cfg_pkg::NUM_PROG-1:0] programmable_input_level,
  input wire logic [switch_cfg_pkg::HW_SEL_W-1:0] ground_switch_input,
  input wire logic [switch_cfg_pkg::MUX_SEL_W-1:0] mux_serial_select,
  output logic [switch_cfg_pkg::NUM_PROG-1:0] programmable_input_polarity,
  output logic battery_switch_poll_length,
  output logic [switch_cfg_pkg::POLL_CNT_W-1:0] active_poll_cycles,
  output logic overvoltage_protect_disable,
  output logic wetting_limit_2ma,
  output logic low_power_allowed,
  output logic overvoltage_flag,
  output logic wake_request,
  output logic irq_n,
  output logic [switch_cfg_pkg::MUX_SEL_W-1:0] analog_multiplexer_select,
  output logic [switch_cfg_pkg::NUM_PROG-1:0] switch_status,
  output logic global_fault_flag,
  output logic global_irq_flag
);

  import switch_cfg_pkg::*;

  frame_link_if lnk ();

  // ==========================================================================
  // link-domain shifter
  frame_shifter u_shifter (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .mosi(mosi),
    .lnk(lnk.shifter)
  );

  // ==========================================================================
  // pin synchronisers
  logic cs_q1_r;
  logic cs_q2_r;
  logic ovr_q1_r;
  logic ovr_q2_r;
  logic supply_q1_r;
  logic supply_q2_r;
  logic wake_q1_r;
  logic wake_q2_r;
  logic [NUM_PROG-1:0] level_q1_r;
  logic [NUM_PROG-1:0] level_q2_r;
  logic [HW_SEL_W-1:0] gsw_q1_r;
  logic [HW_SEL_W-1:0] gsw_q2_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cs_q1_r <= 1'b1;
      cs_q2_r <= 1'b1;
      wake_q1_r <= 1'b1;
      wake_q2_r <= 1'b1;
      ovr_q1_r <= 1'b0;
      ovr_q2_r <= 1'b0;
      supply_q1_r <= 1'b0;
      supply_q2_r <= 1'b0;
      level_q1_r <= '0;
      level_q2_r <= '0;
      gsw_q1_r <= '0;
      gsw_q2_r <= '0;
    end else begin
      cs_q1_r <= chip_select_n;
      cs_q2_r <= cs_q1_r;
      wake_q1_r <= wake_n;
      wake_q2_r <= wake_q1_r;
      ovr_q1_r <= battery_supply_overvoltage;
      ovr_q2_r <= ovr_q1_r;
      supply_q1_r <= logic_supply_present;
      supply_q2_r <= supply_q1_r;
      level_q1_r <= programmable_input_level;
      level_q2_r <= level_q1_r;
      gsw_q1_r <= ground_switch_input;
      gsw_q2_r <= gsw_q1_r;
    end
  end

  // ==========================================================================
  // frame arrival from the link domain
  logic tgl_q1_r;
  logic tgl_q2_r;
  logic tgl_q3_r;
  logic cmd_valid;
  logic [6:0] cmd_addr;
  logic cmd_write;
  logic [DATA_W-1:0] cmd_data;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tgl_q1_r <= 1'b0;
      tgl_q2_r <= 1'b0;
      tgl_q3_r <= 1'b0;
    end else begin
      tgl_q1_r <= lnk.frame_tgl;
      tgl_q2_r <= tgl_q1_r;
      tgl_q3_r <= tgl_q2_r;
    end
  end

  assign cmd_valid = tgl_q2_r ^ tgl_q3_r;
  assign cmd_addr = lnk.frame_word[ADDR_MSB:ADDR_LSB];
  assign cmd_write = lnk.frame_word[RW_BIT] == RW_WRITE;
  assign cmd_data = lnk.frame_word[DATA_W-1:0];

  // ==========================================================================
  // configuration register
  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_nxt;
  logic cfg_wr;
  logic pol_changed;

  assign cfg_wr = cmd_valid && cmd_write && (cmd_addr == ADDR_GLOBAL_CFG) && !low_power_state;

  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_wr) begin
      cfg_nxt = cmd_data[CFG_W-1:0];
    end
  end

  assign pol_changed = cfg_wr && (cfg_nxt[POL_MSB:0] != cfg_r[POL_MSB:0]);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ==========================================================================
  // supply monitoring and poll length
  logic ovr_prev_r;
  logic ovr_enter;
  logic limit_active;
  logic wetting_limit_r;
  logic low_power_allowed_r;
  logic poll_len_r;
  logic [POLL_CNT_W-1:0] poll_cycles_r;
  logic ovp_dis_r;

  assign ovr_enter = ovr_q2_r && !ovr_prev_r;
  assign limit_active = ovr_q2_r && !cfg_r[OVP_DIS_BIT];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ovr_prev_r <= 1'b0;
      wetting_limit_r <= 1'b0;
      low_power_allowed_r <= 1'b1;
      ovp_dis_r <= 1'b0;
    end else begin
      ovr_prev_r <= ovr_q2_r;
      wetting_limit_r <= limit_active;
      low_power_allowed_r <= !limit_active;
      ovp_dis_r <= cfg_r[OVP_DIS_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      poll_len_r <= 1'b0;
      poll_cycles_r <= POLL_LONG_COUNT;
    end else begin
      poll_len_r <= cfg_r[POLL_LEN_BIT];
      poll_cycles_r <= cfg_r[POLL_LEN_BIT] ? POLL_CNT_W'(POLL_SHORT_CYCLES) : POLL_LONG_COUNT;
    end
  end

  // ==========================================================================
  // wake qualification
  logic wake_prev_r;
  logic wake_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_prev_r <= 1'b1;
      wake_r <= 1'b0;
    end else begin
      wake_prev_r <= wake_q2_r;
      wake_r <= wake_prev_r && !wake_q2_r && low_power_state
        && (cfg_r[WAKE_QUAL_BIT] || supply_q2_r);
    end
  end

  // ==========================================================================
  // switch status with polarity
  logic [NUM_PROG-1:0] status_nxt;
  logic [NUM_PROG-1:0] status_r;
  logic status_changed;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PROG; gi++) begin : g_status
      assign status_nxt[gi] = cfg_r[gi] ? level_q2_r[gi] : !level_q2_r[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status_changed = status_nxt != status_r;

  // ==========================================================================
  // analog multiplexer selection
  logic [MUX_SEL_W-1:0] mux_sel_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mux_sel_r <= '0;
    end else begin
      case (mux_mode_t'(cfg_r[MUX_CFG_MSB:MUX_CFG_LSB]))
        MUX_HW_TWO: begin
          mux_sel_r <= MUX_SEL_W'(gsw_q2_r[HW_SEL_W-2:0]);
        end
        MUX_HW_THREE: begin
          mux_sel_r <= MUX_SEL_W'(gsw_q2_r);
        end
        default: begin
          mux_sel_r <= mux_serial_select;
        end
      endcase
    end
  end

  // ==========================================================================
  // global flags
  logic irq_event;
  logic irq_clear;
  logic irq_flag_r;
  logic fault_clear;
  logic fault_flag_r;
  logic ovr_flag_r;

  assign irq_event = switch_change_event || status_changed || pol_changed;
  assign irq_clear = cmd_valid && (cmd_addr == ADDR_GLOBAL_CFG);
  assign fault_clear = cmd_valid && !cmd_write && (cmd_addr == ADDR_FAULT_STATUS)
    && !fault_present && !ovr_q2_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_flag_r <= 1'b0;
    end else if (irq_event) begin
      irq_flag_r <= 1'b1;
    end else if (irq_clear) begin
      irq_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_flag_r <= 1'b0;
    end else if (fault_event || ovr_enter) begin
      fault_flag_r <= 1'b1;
    end else if (fault_clear) begin
      fault_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ovr_flag_r <= 1'b0;
    end else if (ovr_enter) begin
      ovr_flag_r <= 1'b1;
    end else if (fault_clear) begin
      ovr_flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // interrupt pin sequencing
  irq_state_t irq_state_r;
  irq_state_t irq_state_nxt;
  logic [PULSE_CNT_W-1:0] pulse_cnt_r;
  logic irq_n_r;

  always_comb begin
    irq_state_nxt = irq_state_r;
    case (irq_state_r)
      IRQ_IDLE: begin
        if (irq_event) begin
          irq_state_nxt = cfg_r[IRQ_STYLE_BIT] ? IRQ_PULSE : IRQ_HELD;
        end
      end
      IRQ_HELD: begin
        if (irq_clear && !irq_event) begin
          irq_state_nxt = IRQ_IDLE;
        end
      end
      IRQ_PULSE: begin
        if (pulse_cnt_r == PULSE_CNT_W'(IRQ_PULSE_CYCLES - 1)) begin
          irq_state_nxt = IRQ_IDLE;
        end
      end
      default: begin
        irq_state_nxt = IRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_state_r <= IRQ_IDLE;
      irq_n_r <= 1'b1;
    end else begin
      irq_state_r <= irq_state_nxt;
      irq_n_r <= irq_state_nxt == IRQ_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pulse_cnt_r <= '0;
    end else if (irq_state_r == IRQ_PULSE) begin
      pulse_cnt_r <= pulse_cnt_r + PULSE_CNT_W'(1);
    end else begin
      pulse_cnt_r <= '0;
    end
  end

  // ==========================================================================
  // answer word for the next frame
  logic [FRAME_W-1:0] resp_r;
  logic [1:0] flag_bits;
  logic [CFG_W-1:0] ovr_word;

  assign flag_bits = {fault_flag_r, irq_flag_r};
  assign ovr_word = CFG_W'(ovr_flag_r) << OV_FLAG_BIT;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      resp_r <= '0;
    end else if (cmd_valid) begin
      case (cmd_addr)
        ADDR_LINK_CHECK: begin
          resp_r <= {RESP_UPPER, LINK_CHECK_WORD};
        end
        ADDR_GLOBAL_CFG: begin
          resp_r <= {RESP_UPPER, flag_bits, UNUSED_BITS, cfg_nxt};
        end
        ADDR_FAULT_STATUS: begin
          resp_r <= {RESP_UPPER, flag_bits, UNUSED_BITS, ovr_word};
        end
        default: begin
          resp_r <= {RESP_UPPER, flag_bits, UNUSED_BITS, CFG_W'(0)};
        end
      endcase
    end
  end

  assign lnk.resp_word = resp_r;

  // ==========================================================================
  // output enable follows chip select
  logic miso_oe_n_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      miso_oe_n_r <= 1'b1;
    end else begin
      miso_oe_n_r <= cs_q2_r;
    end
  end

  // ==========================================================================
  // outputs
  assign miso = lnk.miso;
  assign miso_oe_n = miso_oe_n_r;
  assign programmable_input_polarity = cfg_r[POL_MSB:0];
  assign battery_switch_poll_length = poll_len_r;
  assign active_poll_cycles = poll_cycles_r;
  assign overvoltage_protect_disable = ovp_dis_r;
  assign wetting_limit_2ma = wetting_limit_r;
  assign low_power_allowed = low_power_allowed_r;
  assign overvoltage_flag = ovr_flag_r;
  assign wake_request = wake_r;
  assign irq_n = irq_n_r;
  assign analog_multiplexer_select = mux_sel_r;
  assign switch_status = status_r;
  assign global_fault_flag = fault_flag_r;
  assign global_irq_flag = irq_flag_r;

endmodule : switch_cfg_top

// File: switch_cfg_properties.sv
// concurrent checks on the ports of the configuration register bank
module switch_cfg_properties
  import switch_cfg_pkg::*;
#(
  parameter logic [15:0] POLL_LONG_COUNT = 16'(switch_cfg_pkg::POLL_LONG_CYCLES)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fault_event,
  input wire logic fault_present,
  input wire logic [switch_cfg_pkg::NUM_PROG-1:0] programmable_input_level,
  input wire logic [switch_cfg_pkg::NUM_PROG-1:0] programmable_input_polarity,
  input wire logic battery_switch_poll_length,
  input wire logic [switch_cfg_pkg::POLL_CNT_W-1:0] active_poll_cycles,
  input wire logic overvoltage_protect_disable,
  input wire logic wetting_limit_2ma,
  input wire logic low_power_allowed,
  input wire logic overvoltage_flag,
  input wire logic irq_n,
  input wire logic [switch_cfg_pkg::NUM_PROG-1:0] switch_status,
  input wire logic global_fault_flag,
  input wire logic global_irq_flag
);
  import switch_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // assertions
  a_reset_defaults: assert property ($rose(rst_n) |-> programmable_input_polarity == 12'hFFF
    && !battery_switch_poll_length && !overvoltage_protect_disable && !global_irq_flag && !global_fault_flag)
    else $error("register defaults wrong after reset");
  a_poll_count: assert property (active_poll_cycles == (battery_switch_poll_length ? 16'(POLL_SHORT_CYCLES)
    : POLL_LONG_COUNT)) else $error("poll count does not match poll length");
  a_lowpower_block: assert property (wetting_limit_2ma |-> !low_power_allowed)
    else $error("sleep allowed while current limited");
  a_ovp_disabled: assert property (overvoltage_protect_disable |-> !wetting_limit_2ma && low_power_allowed)
    else $error("limit active with protection disabled");
  a_ov_flag_sets: assert property ($rose(wetting_limit_2ma) |-> ##[0:2] overvoltage_flag)
    else $error("overvoltage flag not set");
  a_status_match: assert property (($stable(programmable_input_level) && $stable(programmable_input_polarity))[*6]
    |-> switch_status == ~(programmable_input_level ^ programmable_input_polarity))
    else $error("closed switch not reported as one");
  a_polarity_irq: assert property ($changed(programmable_input_polarity) |=> global_irq_flag)
    else $error("no interrupt on polarity change");
  a_irq_pin_low: assert property ($rose(global_irq_flag) |-> !irq_n)
    else $error("interrupt pin not low on event");
  a_fault_set: assert property (fault_event |=> global_fault_flag)
    else $error("fault flag not set");
  a_fault_clear: assert property ($fell(global_fault_flag) |-> !$past(fault_present))
    else $error("fault flag cleared while fault present");
  c_irq: cover property ($fell(irq_n));
  c_limit: cover property ($rose(wetting_limit_2ma));
  c_fault_clear: cover property ($fell(global_fault_flag));
endmodule : switch_cfg_properties

bind switch_cfg_top switch_cfg_properties #(.POLL_LONG_COUNT(POLL_LONG_COUNT)) i_props (.sys_clk, .rst_n,
  .fault_event, .fault_present, .programmable_input_level, .programmable_input_polarity, .battery_switch_poll_length,
  .active_poll_cycles, .overvoltage_protect_disable, .wetting_limit_2ma, .low_power_allowed, .overvoltage_flag,
  .irq_n, .switch_status, .global_fault_flag, .global_irq_flag);

// File: host_link_model.sv
// host side of the serial link: frame master with a stopped clock between frames
module host_link_model (
  output logic link_clk,
  output logic chip_select_n,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  // ==========================================================================
  // clock pulses and frames
  task automatic pulses(input int n);
    repeat (n) begin
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
  endtask : pulses
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    chip_select_n = 1'b0;
    #103;
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
      rsp[i] = miso;
    end
    #20 chip_select_n = 1'b1;
    mosi = ~mosi;
    #407;
  endtask : xfer
endmodule : host_link_model

// File: tb_switch_detector_global_config.sv
// self-checking bench of the global configuration register bank
module tb_switch_detector_global_config;
  import switch_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, s); end end
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic link_clk, chip_select_n, mosi, miso, battery_switch_poll_length, overvoltage_protect_disable;
  logic wetting_limit_2ma, low_power_allowed, overvoltage_flag, wake_request, irq_n, global_fault_flag, global_irq_flag;
  logic battery_supply_overvoltage = 1'b0, logic_supply_present = 1'b0, wake_n = 1'b1, low_power_state = 1'b0;
  logic fault_event = 1'b0, fault_present = 1'b0, switch_change_event = 1'b0, fm = 1'b0, irq_m = 1'b0;
  logic [11:0] programmable_input_level = 12'h000, programmable_input_polarity, switch_status;
  logic [2:0] ground_switch_input = 3'h0;
  logic [5:0] mux_serial_select = 6'h00, analog_multiplexer_select;
  logic [15:0] active_poll_cycles;
  logic [31:0] rsp, exp_rsp;
  logic exp_vld = 1'b0;
  logic miso_oe_n, oe_low = 1'b0;
  logic [17:0] cfg_m = CFG_RESET;
  int err_total = 0, comparisons = 0, cycles = 0;
  always #10 sys_clk = ~sys_clk;
  host_link_model i_host (.link_clk, .chip_select_n, .mosi, .miso);
  switch_cfg_top #(.POLL_LONG_COUNT(16'h0064)) i_dut (.*, .miso_oe_n(miso_oe_n));
  // remembers whether the answer pin was enabled at the last link edge
  always @(posedge link_clk) oe_low <= !miso_oe_n;
  // ==========================================================================
  // helpers
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 15000) begin
      err_total++;
      end_sim();
    end
  end
  function automatic logic [5:0] exp_mux(input logic [1:0] m);
    case (m)
      MUX_HW_TWO: return {4'h0, ground_switch_input[1:0]};
      MUX_HW_THREE: return {3'h0, ground_switch_input};
      default: return mux_serial_select;
    endcase
  endfunction : exp_mux
  task automatic xf(input logic [6:0] a, input logic w, input logic [23:0] d);
    i_host.xfer({a, w, d}, rsp);
    if (exp_vld) `CHK("answer", exp_rsp, rsp)
    `CHK("miso_oe_n", 2'b11, {oe_low, miso_oe_n})
    exp_rsp = {8'h00, LINK_CHECK_WORD};
    exp_vld = (a == ADDR_LINK_CHECK);
    @(negedge sys_clk);
  endtask : xf
  task automatic cfg_acc(input logic w, input logic [23:0] d);
    logic [17:0] nxt;
    nxt = (w && !low_power_state) ? d[17:0] : cfg_m;
    xf(ADDR_GLOBAL_CFG, w, d);
    exp_rsp = {RESP_UPPER, fm, irq_m, UNUSED_BITS, nxt};
    exp_vld = 1'b1;
    irq_m = nxt[11:0] != cfg_m[11:0];
    cfg_m = nxt;
    repeat (10) @(negedge sys_clk);
    `CHK("polarity", cfg_m[11:0], programmable_input_polarity)
    `CHK("status", ~(programmable_input_level ^ cfg_m[11:0]), switch_status)
    `CHK("poll", cfg_m[17:16], {battery_switch_poll_length, overvoltage_protect_disable})
    `CHK("cycles", (cfg_m[17] ? 16'(POLL_SHORT_CYCLES) : 16'h0064), active_poll_cycles)
  endtask : cfg_acc
  task automatic wake_try(input logic q, input logic exp);
    logic seen;
    cfg_acc(1'b1, {6'h00, cfg_m[17:16], q, cfg_m[14:0]});
    seen = 1'b0;
    low_power_state = 1'b1;
    wake_n = 1'b0;
    repeat (10) @(negedge sys_clk) seen |= wake_request;
    `CHK("wake", exp, seen)
    wake_n = 1'b1;
    low_power_state = 1'b0;
  endtask : wake_try
  task automatic fault_rd();
    xf(ADDR_FAULT_STATUS, 1'b0, 24'h000000);
    exp_rsp = {RESP_UPPER, fm, irq_m, UNUSED_BITS, 17'h00000, 1'b1};
    exp_vld = 1'b1;
  endtask : fault_rd
  task automatic irq_event();
    switch_change_event = 1'b1;
    @(negedge sys_clk) switch_change_event = 1'b0;
    irq_m = 1'b1;
  endtask : irq_event
  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h5FC74855));
    i_host.pulses(4);
    @(negedge sys_clk) rst_n = 1'b1;
    i_host.pulses(2);
    @(negedge sys_clk) programmable_input_level = 12'($urandom);
    irq_m = |programmable_input_level;
    repeat (10) @(negedge sys_clk);
    cfg_acc(1'b0, 24'h000000);
    cfg_acc(1'b1, 24'hFC0000);
    repeat (6) cfg_acc(1'b1, 24'($urandom));
    low_power_state = 1'b1;
    cfg_acc(1'b1, ~{6'h00, cfg_m});
    low_power_state = 1'b0;
    for (int m = 0; m < 4; m++) begin
      cfg_acc(1'b1, {6'h00, cfg_m[17:14], 2'(m), cfg_m[11:0]});
      ground_switch_input = 3'($urandom);
      mux_serial_select = 6'($urandom);
      repeat (5) @(negedge sys_clk);
      `CHK("mux", exp_mux(2'(m)), analog_multiplexer_select)
    end
    wake_try(1'b0, 1'b0);
    wake_try(1'b1, 1'b1);
    logic_supply_present = 1'b1;
    wake_try(1'b0, 1'b1);
    cfg_acc(1'b1, {6'h00, cfg_m[17:15], 1'b1, cfg_m[13:0]});
    irq_event();
    `CHK("irq_n", 1'b0, irq_n)
    repeat (600) @(negedge sys_clk);
    `CHK("irq_n", 2'b11, {irq_n, global_irq_flag})
    cfg_acc(1'b1, {6'h00, cfg_m[17:15], 1'b0, cfg_m[13:0]});
    irq_event();
    repeat (600) @(negedge sys_clk);
    `CHK("irq_n", 1'b0, irq_n)
    cfg_acc(1'b0, 24'h000000);
    `CHK("irq_n", 2'b10, {irq_n, global_irq_flag})
    cfg_acc(1'b1, {6'h00, cfg_m[17], 1'b0, cfg_m[15:0]});
    battery_supply_overvoltage = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK("ov", 4'b1011, {wetting_limit_2ma, low_power_allowed, overvoltage_flag, global_fault_flag})
    fm = 1'b1;
    cfg_acc(1'b1, {6'h00, cfg_m[17], 1'b1, cfg_m[15:0]});
    `CHK("ov", 3'b011, {wetting_limit_2ma, low_power_allowed, overvoltage_flag})
    battery_supply_overvoltage = 1'b0;
    fault_present = 1'b1;
    fault_event = 1'b1;
    @(negedge sys_clk) fault_event = 1'b0;
    fault_rd();
    `CHK("fault", 1'b1, global_fault_flag)
    fault_present = 1'b0;
    fault_rd();
    `CHK("fault", 2'b00, {global_fault_flag, overvoltage_flag})
    xf(ADDR_LINK_CHECK, 1'b0, 24'h000000);
    xf(ADDR_LINK_CHECK, 1'b0, 24'h000000);
    end_sim();
  end
endmodule : tb_switch_detector_global_config
